// ===== hw/cgr_regs.sv
// Clock generator configuration bytes 9 to 14 with stop gating for processor and bus clocks.
// Assumes a byte register port from the management bus engine, straps stable at reset release.
//
// Behaviour
// - Byte 9 bit 7 makes free bus output 0 stoppable; resets 0.
// - Byte 9 bit 6 reads the trusted-mode strap caught at reset.
// - Byte 9 bit 3 enters test mode when 1; resets 0.
// - Byte 9 bit 4 picks tri-state or divided reference in test mode.
// - Byte 10 bit 7 reads the latched shared output select strap.
// - Byte 10 bit 6 powers third PLL; reset value follows that strap.
// - Byte 10 bit 5 powers second PLL; resets 1.
// - Byte 10 bits 4..2 enable serial ref, bus and processor dividers; reset 1.
// - Byte 10 bits 1,0 make processor outputs 1,0 stoppable; reset 1.
// - Byte 11 bit 0 makes processor output 2 stoppable; upper bits reserved.
// - Byte 13 bits 7..5 bus drive strength code, default 011.
// - Byte 13 bits 4..2 USB drive strength code, default 010.
// - Reference code is byte13 bit1, byte9 bit5, byte13 bit0; default 010.
// - Byte 14 bit 5 picks first PLL spread 0.5 or 1 percent.
// - Writing 0 to byte 14 bit 0 halts stoppable bus outputs whole.
// - Writing 1 to byte 14 bit 0 restarts them without short pulses.
// - Bus clocks resume within two bus periods after stop release.
// - Stoppable processor outputs halt within two to six periods, true high.
`timescale 1ns/100ps
module cgr_regs
    import cgr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    input wire logic trusted_mode_strap_i,
    input wire logic shared_output_select_strap_i,
    input wire logic cpu_stop_n_i,
    input wire logic pci_stop_n_i,
    input wire logic cpu_tick_i,
    input wire logic pci_tick_i,
    input wire logic src_stoppable_i,
    output logic [2:0] proc_halt_o,
    output logic pci_halt_o,
    output logic free_pci_out0_halt_o,
    output logic src_halt_o,
    output logic trusted_mode_o,
    output logic panel_100mhz_clock_sel_o,
    output logic test_mode_o,
    output logic test_ref_div_sel_o,
    output logic third_pll_power_o,
    output logic second_pll_power_o,
    output logic serial_ref_divider_enable_o,
    output logic pci_divider_enable_o,
    output logic proc_divider_enable_o,
    output logic [5:0] byte_count_field_o,
    output logic [2:0] pci_drive_strength_code_o,
    output logic [2:0] usb_drive_strength_code_o,
    output logic [2:0] ref_drive_strength_code_o,
    output logic pll1_spread_1pct_o,
    output logic software_bus_clock_halt_o
);
    // ==========================================================
    // Declarations
    logic [7:0] regs [CGR_NREG];
    logic [7:0] next_regs [CGR_NREG];
    logic [7:0] rd_val [CGR_NREG];
    logic trusted_mode_strap, next_trusted_mode_strap;
    logic shared_output_select_strap, next_shared_output_select_strap;
    logic [7:0] next_rdata;
    logic next_ack;
    logic in_map;
    logic [7:0] idx_full;
    logic [2:0] idx;
    logic [2:0] proc_stoppable;
    logic [2:0] pci_halt_bus;
    cgr_stop_if cpu_if ();
    cgr_stop_if pci_if ();

    assign idx_full = reg_addr_i - CGR_OFS_FIRST;
    assign idx = idx_full[2:0];
    assign in_map = (reg_addr_i >= CGR_OFS_FIRST) && (reg_addr_i <= CGR_OFS_LAST);

    // ==========================================================
    // Strap capture
    // Straps are caught while reset is held and kept afterwards
    always_comb begin
        next_trusted_mode_strap = trusted_mode_strap;
        next_shared_output_select_strap = shared_output_select_strap;
        if (!resetn_i) begin
            next_trusted_mode_strap = trusted_mode_strap_i;
            next_shared_output_select_strap = shared_output_select_strap_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        trusted_mode_strap <= next_trusted_mode_strap;
        shared_output_select_strap <= next_shared_output_select_strap;
    end

    // ==========================================================
    // Register entries
    // Only bits in the write mask ever change, so reserved and strap bits stay clear
    for (genvar gi = 0; gi < CGR_NREG; gi++) begin : g_reg
        logic [7:0] rst_val;
        logic [7:0] ro_bits;
        always_comb begin
            rst_val = CGR_RST_VAL[gi];
            ro_bits = 8'h00;
            if (gi == CGR_I_PLL) begin
                rst_val[CGR_B_PLL3] = shared_output_select_strap_i;
                ro_bits[CGR_B_SHSEL] = shared_output_select_strap;
            end
            if (gi == CGR_I_STOP) begin
                ro_bits[CGR_B_TRUST] = trusted_mode_strap;
            end
            next_regs[gi] = regs[gi];
            if (ce_i && reg_wr_i && in_map && (idx == 3'(gi))) begin
                next_regs[gi] = (reg_wdata_i & CGR_WR_MASK[gi]) |
                    (regs[gi] & ~CGR_WR_MASK[gi]);
            end
        end

        always_ff @(posedge sys_clk_i) begin
            if (!resetn_i) begin
                regs[gi] <= rst_val;
            end else begin
                regs[gi] <= next_regs[gi];
            end
        end

        assign rd_val[gi] = regs[gi] | ro_bits;
    end

    // ==========================================================
    // Read port
    // Unmapped offsets read as zero so a stray block read stays harmless
    always_comb begin
        next_rdata = reg_rdata_o;
        next_ack = reg_ack_o;
        if (ce_i) begin
            next_ack = reg_rd_i;
            if (reg_rd_i) begin
                next_rdata = in_map ? rd_val[idx] : 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
            reg_ack_o <= 1'b0;
        end else begin
            reg_rdata_o <= next_rdata;
            reg_ack_o <= next_ack;
        end
    end

    // ==========================================================
    // Configuration outputs
    assign trusted_mode_o = trusted_mode_strap;
    assign panel_100mhz_clock_sel_o = shared_output_select_strap;
    assign test_mode_o = regs[CGR_I_STOP][CGR_B_TENT];
    assign test_ref_div_sel_o = regs[CGR_I_STOP][CGR_B_TSEL];
    assign third_pll_power_o = regs[CGR_I_PLL][CGR_B_PLL3];
    assign second_pll_power_o = regs[CGR_I_PLL][CGR_B_PLL2];
    assign serial_ref_divider_enable_o = regs[CGR_I_PLL][CGR_B_SRCDIV];
    assign pci_divider_enable_o = regs[CGR_I_PLL][CGR_B_PCIDIV];
    assign proc_divider_enable_o = regs[CGR_I_PLL][CGR_B_CPUDIV];
    assign byte_count_field_o = regs[CGR_I_BCNT][5:0];
    assign pci_drive_strength_code_o = regs[CGR_I_DRV][7:5];
    assign usb_drive_strength_code_o = regs[CGR_I_DRV][4:2];
    assign ref_drive_strength_code_o = {regs[CGR_I_DRV][CGR_B_REFTOP],
        regs[CGR_I_STOP][CGR_B_REFMID], regs[CGR_I_DRV][CGR_B_REFLOW]};
    assign pll1_spread_1pct_o = regs[CGR_I_SPRD][CGR_B_SPRD];
    assign software_bus_clock_halt_o = ~regs[CGR_I_SPRD][CGR_B_SWHALT];

    // ==========================================================
    // Stop gating
    assign proc_stoppable = {regs[CGR_I_CPU2][CGR_B_CPU2], regs[CGR_I_PLL][CGR_B_CPU1],
        regs[CGR_I_PLL][CGR_B_CPU0]};
    assign cpu_if.stop_req = ~cpu_stop_n_i;
    assign cpu_if.tick = cpu_tick_i;
    assign cpu_if.stoppable = proc_stoppable;
    // Software halt and the pin share one path, so both stop on the same tick
    assign pci_if.stop_req = ~pci_stop_n_i | ~regs[CGR_I_SPRD][CGR_B_SWHALT];
    assign pci_if.tick = pci_tick_i;
    assign pci_if.stoppable = {src_stoppable_i, regs[CGR_I_STOP][CGR_B_PCIF0], 1'b1};

    cgr_cpu_stop u_cpu_stop (
        .sys_clk_i (sys_clk_i),
        .resetn_i (resetn_i),
        .ce_i (ce_i),
        .stop (cpu_if.gate)
    );

    cgr_pci_stop u_pci_stop (
        .sys_clk_i (sys_clk_i),
        .resetn_i (resetn_i),
        .ce_i (ce_i),
        .stop (pci_if.gate)
    );

    assign pci_halt_bus = pci_if.halt;
    assign proc_halt_o = cpu_if.halt;
    assign pci_halt_o = pci_halt_bus[0];
    assign free_pci_out0_halt_o = pci_halt_bus[1];
    assign src_halt_o = pci_halt_bus[2];

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_wr_pll;
        ce_i && reg_wr_i && reg_addr_i == CGR_OFS_PLL;
    endsequence
    sequence s_sw_halt_tick;
        ce_i && pci_tick_i && !regs[CGR_I_SPRD][CGR_B_SWHALT];
    endsequence
    sequence s_rd_at(logic [7:0] ofs);
        ce_i && reg_rd_i && reg_addr_i == ofs;
    endsequence
    sequence s_wr_at(logic [7:0] ofs);
        ce_i && reg_wr_i && reg_addr_i == ofs;
    endsequence

    property p_pll2_write;
        s_wr_pll |=> second_pll_power_o == $past(reg_wdata_i[CGR_B_PLL2]);
    endproperty
    a_pll2_write: assert property (p_pll2_write) else $error("pll2 bit");

    property p_sw_halt;
        s_sw_halt_tick |=> pci_halt_o;
    endproperty
    a_sw_halt: assert property (p_sw_halt) else $error("software halt lost");

    property p_rd_ack;
        ce_i && reg_rd_i |=> reg_ack_o;
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not answered");

    property p_cpu2_reserved;
        s_rd_at(CGR_OFS_CPU2) |=> reg_rdata_o[7:1] == 7'h00;
    endproperty
    a_cpu2_reserved: assert property (p_cpu2_reserved) else $error("reserved");

    property p_trust_readback;
        s_rd_at(CGR_OFS_STOP) |=> reg_rdata_o[CGR_B_TRUST] == trusted_mode_o;
    endproperty
    a_trust_readback: assert property (p_trust_readback) else $error("strap bit");

    property p_pll3_init;
        $rose(resetn_i) |-> third_pll_power_o == panel_100mhz_clock_sel_o;
    endproperty
    a_pll3_init: assert property (p_pll3_init) else $error("pll3 reset");

    property p_ref_top_write;
        ce_i && reg_wr_i && reg_addr_i == CGR_OFS_DRV
            |=> ref_drive_strength_code_o[2] == $past(reg_wdata_i[CGR_B_REFTOP]);
    endproperty
    a_ref_top_write: assert property (p_ref_top_write) else $error("ref top");

    property p_unmapped_zero;
        ce_i && reg_rd_i && !in_map |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped");

    property p_bcnt_top_zero;
        s_rd_at(CGR_OFS_BCNT) |=> reg_rdata_o[7:6] == 2'h0;
    endproperty
    a_bcnt_top_zero: assert property (p_bcnt_top_zero) else $error("count top");

    property p_ce_freeze;
        !ce_i |=> $stable(pci_drive_strength_code_o) && $stable(usb_drive_strength_code_o);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

    property p_pci_resume;
        ce_i && pci_tick_i && pci_stop_n_i && regs[CGR_I_SPRD][CGR_B_SWHALT]
            |=> {pci_halt_o, free_pci_out0_halt_o, src_halt_o} == 3'h0;
    endproperty
    a_pci_resume: assert property (p_pci_resume) else $error("bus halt kept");

    property p_free0_mask;
        ce_i && pci_tick_i && !regs[CGR_I_STOP][CGR_B_PCIF0] |=> !free_pci_out0_halt_o;
    endproperty
    a_free0_mask: assert property (p_free0_mask) else $error("free halted");

    property p_cpu2_mask;
        ce_i && cpu_tick_i && !regs[CGR_I_CPU2][CGR_B_CPU2] |=> !proc_halt_o[2];
    endproperty
    a_cpu2_mask: assert property (p_cpu2_mask) else $error("cpu2 halted");

    property p_reset_values;
        $rose(resetn_i) |-> byte_count_field_o == CGR_RST_VAL[CGR_I_BCNT][5:0] &&
            second_pll_power_o == CGR_RST_VAL[CGR_I_PLL][CGR_B_PLL2];
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset value");

    property p_spread_write;
        s_wr_at(CGR_OFS_SPRD) |=> pll1_spread_1pct_o == $past(reg_wdata_i[CGR_B_SPRD]);
    endproperty
    a_spread_write: assert property (p_spread_write) else $error("spread bit");

    property p_test_write;
        s_wr_at(CGR_OFS_STOP) |=> test_mode_o == $past(reg_wdata_i[CGR_B_TENT]) &&
            test_ref_div_sel_o == $past(reg_wdata_i[CGR_B_TSEL]);
    endproperty
    a_test_write: assert property (p_test_write) else $error("test bits");
endmodule : cgr_regs

// ===== hw/cgr_pkg.sv
// Constants, field positions, reset values and types for clock generator bytes 9 to 14.
// Assumes a byte-wide register port fed by the serial management bus engine.
package cgr_pkg;
    // ==========================================================
    // Register map
    localparam int CGR_NREG = 6;
    localparam logic [7:0] CGR_OFS_FIRST = 8'h09;
    localparam logic [7:0] CGR_OFS_LAST = 8'h0e;
    localparam logic [7:0] CGR_OFS_STOP = 8'h09;
    localparam logic [7:0] CGR_OFS_PLL = 8'h0a;
    localparam logic [7:0] CGR_OFS_CPU2 = 8'h0b;
    localparam logic [7:0] CGR_OFS_BCNT = 8'h0c;
    localparam logic [7:0] CGR_OFS_DRV = 8'h0d;
    localparam logic [7:0] CGR_OFS_SPRD = 8'h0e;
    localparam int CGR_I_STOP = 0;
    localparam int CGR_I_PLL = 1;
    localparam int CGR_I_CPU2 = 2;
    localparam int CGR_I_BCNT = 3;
    localparam int CGR_I_DRV = 4;
    localparam int CGR_I_SPRD = 5;
    // ==========================================================
    // Writable bits and values after reset, one entry per register
    localparam logic [7:0] CGR_WR_MASK [CGR_NREG] = '{8'hb8, 8'h7f, 8'h01, 8'h3f, 8'hff, 8'h21};
    localparam logic [7:0] CGR_RST_VAL [CGR_NREG] = '{8'h20, 8'h3f, 8'h01, 8'h0d, 8'h68, 8'h01};
    // ==========================================================
    // Field positions
    localparam int CGR_B_PCIF0 = 7;
    localparam int CGR_B_TRUST = 6;
    localparam int CGR_B_REFMID = 5;
    localparam int CGR_B_TSEL = 4;
    localparam int CGR_B_TENT = 3;
    localparam int CGR_B_SHSEL = 7;
    localparam int CGR_B_PLL3 = 6;
    localparam int CGR_B_PLL2 = 5;
    localparam int CGR_B_SRCDIV = 4;
    localparam int CGR_B_PCIDIV = 3;
    localparam int CGR_B_CPUDIV = 2;
    localparam int CGR_B_CPU1 = 1;
    localparam int CGR_B_CPU0 = 0;
    localparam int CGR_B_CPU2 = 0;
    localparam int CGR_B_REFTOP = 1;
    localparam int CGR_B_REFLOW = 0;
    localparam int CGR_B_SPRD = 5;
    localparam int CGR_B_SWHALT = 0;
    // ==========================================================
    // Processor stop sampler
    typedef enum logic [1:0] {
        CGR_CPU_RUN = 2'b00,
        CGR_CPU_SEEN = 2'b01,
        CGR_CPU_ARMED = 2'b10
    } cgr_cpu_state_t;
endpackage : cgr_pkg

// ===== hw/cgr_stop_if.sv
// Stop request, period tick, stoppable mask and halt answer between top and a stop gate.
// Assumes one clock domain; tick marks a period boundary of the gated output clock.
`timescale 1ns/100ps
interface cgr_stop_if;
    logic stop_req;
    logic tick;
    logic [2:0] stoppable;
    logic [2:0] halt;
    modport ctl (output stop_req, output tick, output stoppable, input halt);
    modport gate (input stop_req, input tick, input stoppable, output halt);
endinterface : cgr_stop_if

// ===== hw/cgr_cpu_stop.sv
// Processor clock stop gate: two tick samples of the request, then halt on the next tick.
// Assumes stop_req is active high and tick is a one-cycle pulse per processor clock period.
`timescale 1ns/100ps
module cgr_cpu_stop
    import cgr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    cgr_stop_if.gate stop
);
    cgr_cpu_state_t state, next_state;
    logic [2:0] halt, next_halt;

    // ==========================================================
    // Sampler and halt
    // Halting only on a tick keeps every pulse whole
    always_comb begin
        next_state = state;
        next_halt = halt;
        if (ce_i && stop.tick) begin
            unique case (state)
                CGR_CPU_RUN: next_state = stop.stop_req ? CGR_CPU_SEEN : CGR_CPU_RUN;
                CGR_CPU_SEEN: next_state = stop.stop_req ? CGR_CPU_ARMED : CGR_CPU_RUN;
                CGR_CPU_ARMED: next_state = stop.stop_req ? CGR_CPU_ARMED : CGR_CPU_RUN;
                default: next_state = CGR_CPU_RUN;
            endcase
            if (!stop.stop_req) begin
                next_halt = 3'h0;
            end else if (state == CGR_CPU_ARMED) begin
                next_halt = stop.stoppable;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state <= CGR_CPU_RUN;
            halt <= 3'h0;
        end else begin
            state <= next_state;
            halt <= next_halt;
        end
    end

    assign stop.halt = halt;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_cpu_two_samples;
        $rose(|halt) |-> $past(state) == CGR_CPU_ARMED;
    endproperty
    a_cpu_two_samples: assert property (p_cpu_two_samples) else $error("early");
    property p_cpu_release;
        ce_i && stop.tick && !stop.stop_req |=> halt == 3'h0;
    endproperty
    a_cpu_release: assert property (p_cpu_release) else $error("cpu halt not released");
endmodule : cgr_cpu_stop

// ===== hw/cgr_pci_stop.sv
// Bus clock stop gate: halts and resumes stoppable outputs on the next period tick.
// Assumes stop_req already merges the stop pin and the software halt bit.
`timescale 1ns/100ps
module cgr_pci_stop
    import cgr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    cgr_stop_if.gate stop
);
    logic [2:0] halt, next_halt;

    // ==========================================================
    // Halt register
    always_comb begin
        next_halt = halt;
        if (ce_i && stop.tick) begin
            next_halt = stop.stop_req ? stop.stoppable : 3'h0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            halt <= 3'h0;
        end else begin
            halt <= next_halt;
        end
    end

    assign stop.halt = halt;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_pci_stop_tick;
        ce_i && stop.tick && stop.stop_req |=> halt == $past(stop.stoppable);
    endproperty
    a_pci_stop_tick: assert property (p_pci_stop_tick) else $error("halt missed");
    property p_pci_whole_pulse;
        !(ce_i && stop.tick) |=> $stable(halt);
    endproperty
    a_pci_whole_pulse: assert property (p_pci_whole_pulse) else $error("off tick");
endmodule : cgr_pci_stop

// ===== sim/cgr_host_model.sv
// Management bus engine model: byte writes and reads on the register strobe port.
// Assumes requests start 1 ns after a rising edge and read answers come one cycle later.
`timescale 1ns/100ps
module cgr_host_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_ack_i,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);
    // ==========================================================
    // Idle lines show inverted stale values so a late sample cannot match by luck
    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk_i);
        #1;
        reg_addr_o = addr;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~data;
        reg_addr_o = ~addr;
    endtask : wr
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ack);
        @(posedge sys_clk_i);
        #1;
        reg_addr_o = addr;
        reg_rd_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        ack = reg_ack_i;
        data = reg_rdata_i;
    endtask : rd
endmodule : cgr_host_model

// ===== sim/clock_gen_ctrl_regs_b9_b14_tb.sv
// Self-checking bench for the clock generator bytes 9 to 14 register block.
// Assumes the host model drives the register port; the bench drives pins, straps and ticks.
`timescale 1ns/100ps
module clock_gen_ctrl_regs_b9_b14_tb;
    import cgr_pkg::*;
    logic sys_clk_i, resetn_i, ce_i, wr, rd, ack, trust, shsel, cstop_n, pstop_n;
    logic ctick, ptick, src_stop, pci_h, f0_h, src_h, trust_o, panel, tmode, tsel, pll3, pll2;
    logic sdiv, pdiv, cdiv, spread, swhalt;
    logic [7:0] addr, wdata, rdata;
    logic [2:0] proc_h, pcode, ucode, rcode;
    logic [5:0] bcnt;
    logic [7:0] rst_tbl [6];
    logic [7:0] msk_tbl [6] = '{8'hb8, 8'h7f, 8'h01, 8'h3f, 8'hff, 8'h21};
    int failures = 0;
    int checks = 0;
    cgr_regs u_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_ack_o(ack), .trusted_mode_strap_i(trust),
        .shared_output_select_strap_i(shsel), .cpu_stop_n_i(cstop_n), .pci_stop_n_i(pstop_n),
        .cpu_tick_i(ctick), .pci_tick_i(ptick), .src_stoppable_i(src_stop),
        .proc_halt_o(proc_h), .pci_halt_o(pci_h), .free_pci_out0_halt_o(f0_h),
        .src_halt_o(src_h), .trusted_mode_o(trust_o), .panel_100mhz_clock_sel_o(panel),
        .test_mode_o(tmode), .test_ref_div_sel_o(tsel), .third_pll_power_o(pll3),
        .second_pll_power_o(pll2), .serial_ref_divider_enable_o(sdiv),
        .pci_divider_enable_o(pdiv), .proc_divider_enable_o(cdiv), .byte_count_field_o(bcnt),
        .pci_drive_strength_code_o(pcode), .usb_drive_strength_code_o(ucode),
        .ref_drive_strength_code_o(rcode), .pll1_spread_1pct_o(spread),
        .software_bus_clock_halt_o(swhalt));
    cgr_host_model u_host (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdata), .reg_ack_i(ack),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    // ==========================================================
    // Clock, checking and closing
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic k;
        u_host.rd(a, d, k);
        chk("read ack", {7'h00, k}, 8'h01);
        chk($sformatf("byte %h", a), d, exp);
    endtask : rdchk
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : idle
    // Ticks are single-cycle pulses, as the period boundaries of the output clocks
    task automatic tick(input bit cpu);
        @(posedge sys_clk_i);
        #1;
        if (cpu) ctick = 1'b1;
        else ptick = 1'b1;
        idle(1);
        ctick = 1'b0;
        ptick = 1'b0;
        idle(1);
    endtask : tick
    task automatic do_reset(input logic s);
        resetn_i = 1'b0;
        trust = s;
        shsel = s;
        idle(16);
        resetn_i = 1'b1;
    endtask : do_reset
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        #1000000;
        failures++;
        wrap_up();
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic s;
        logic [7:0] p;
        resetn_i = 1'b0;
        ce_i = 1'b1;
        {trust, shsel, ctick, ptick} = 4'h0;
        {cstop_n, pstop_n, src_stop} = 3'b111;
        for (int n = 1; n >= 0; n--) begin
            s = n[0];
            do_reset(s);
            rst_tbl = '{{1'b0, s, 6'h20}, {s, s, 6'h3f}, 8'h01, 8'h0d, 8'h68, 8'h01};
            for (int i = 0; i < 6; i++) rdchk(CGR_OFS_FIRST + 8'(i), rst_tbl[i]);
            chk("flags", {trust_o, panel, pll3, pll2, sdiv, pdiv, cdiv, tmode},
                {s, s, s, 5'h1e});
            chk("more", {4'h0, tsel, spread, swhalt, |proc_h}, 8'h00);
            chk("codes", {pcode, ucode, 2'b00}, 8'h68);
            chk("ref code", {5'h00, rcode}, 8'h02);
            chk("count", {2'b00, bcnt}, 8'h0d);
            // Strobes while the clock enable is low must leave state alone
            ce_i = 1'b0;
            u_host.wr(CGR_OFS_DRV, 8'h55);
            ce_i = 1'b1;
            rdchk(CGR_OFS_DRV, 8'h68);
            for (int j = 0; j < 2; j++) begin
                p = j ? 8'h00 : 8'hff;
                for (int i = 0; i < 8; i++) u_host.wr(8'h08 + 8'(i), p);
                for (int i = 0; i < 6; i++)
                    rdchk(CGR_OFS_FIRST + 8'(i),
                        (rst_tbl[i] & ~msk_tbl[i]) | (p & msk_tbl[i]));
                rdchk(8'h08, 8'h00);
                rdchk(8'h0f, 8'h00);
                chk("ctl", {tmode, tsel, spread, pll2, sdiv, pdiv, cdiv, pll3},
                    p);
                chk("sw halt", {7'h00, swhalt}, {7'h00, ~p[0]});
                chk("codes", {pcode, ucode, rcode[2], rcode[0]},
                    p);
                chk("ref mid", {7'h00, rcode[1]}, {7'h00, p[5]});
                chk("count", {2'b00, bcnt}, p & 8'h3f);
            end
        end
        // Bus stop through the software bit, then through the pin
        u_host.wr(CGR_OFS_STOP, 8'h80);
        u_host.wr(CGR_OFS_PLL, 8'h03);
        idle(2);
        tick(0);
        chk("bus halt", {5'h00, pci_h, f0_h, src_h}, 8'h07);
        u_host.wr(CGR_OFS_SPRD, 8'h01);
        idle(2);
        tick(0);
        chk("bus halt", {5'h00, pci_h, f0_h, src_h}, 8'h00);
        u_host.wr(CGR_OFS_STOP, 8'h00);
        src_stop = 1'b0;
        pstop_n = 1'b0;
        idle(2);
        tick(0);
        chk("pin halt", {5'h00, pci_h, f0_h, src_h}, 8'h04);
        pstop_n = 1'b1;
        idle(1);
        tick(0);
        chk("pin halt", {5'h00, pci_h, f0_h, src_h}, 8'h00);
        // Processor stop: halts only on the third tick, and only the stoppable outputs
        cstop_n = 1'b0;
        for (int k = 0; k < 3; k++) begin
            idle(3);
            tick(1);
            chk("proc halt", {5'h00, proc_h},
                (k == 2) ? 8'h03 : 8'h00);
        end
        // A mask change while armed takes effect at the next tick
        u_host.wr(CGR_OFS_CPU2, 8'h01);
        tick(1);
        chk("proc halt", {5'h00, proc_h}, 8'h07);
        cstop_n = 1'b1;
        idle(2);
        tick(1);
        chk("proc halt", {5'h00, proc_h}, 8'h00);
        wrap_up();
    end
endmodule : clock_gen_ctrl_regs_b9_b14_tb
